// [hw/dcs_regs.sv]
`timescale 1ns/1ps
// Calibration memory manager and sync status registers
module dcs_regs
    import dcs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       sync_alarm_in,
    input  wire logic [1:0] sync_auto_quadrant,
    output logic      [1:0] sync_quadrant_sel,
    output logic            sync_auto_update_en,
    output logic            sync_update_pulse,
    input  wire logic [5:0] start_a_result,
    output logic      [7:0] factory_addr,
    input  wire logic [5:0] factory_data,
    input  wire logic [7:0] core_trim_addr,
    output logic      [5:0] core_trim_data
);
    // Whole block state
    typedef struct packed {
        dcs_seq_t   seq;          // Sequencer state
        logic [7:0] seq_addr;     // Word under work
        logic [3:0] seq_tick;     // Calibration ticks within a word
        logic       sc_done;      // Self-calibration finished
        logic       xf_done;      // Transfer finished
        logic [2:0] mem_en;       // Access enables, bits 3:1
        logic       force_def;    // Uncalibrated operation
        logic       fill_done;    // Defaults fully loaded
        logic [1:0] trim_state;   // Working memory state code
        logic [2:0] cal_div;      // Calibration clock setting
        logic [7:0] trim_addr;    // Address register
        logic [5:0] trim_data;    // Data register
        logic       manual_sync;  // Manual synchronizer mode
        logic       sync_alarm;   // Captured alarm
        logic       ext_quad_en;  // Software quadrant select
        logic [1:0] ext_quad;     // Software quadrant value
        logic [1:0] cur_quad;     // Quadrant in use
        logic       sync_upd;     // Update request pulse
        logic [7:0] rdata;        // Read data
    } dcs_main_t;

    dcs_main_t  s_reg;      // Registered state
    dcs_main_t  s_next;     // Next state
    logic       cal_tick;   // Divided calibration clock tick
    logic       seq_run;    // Self-calibration or transfer running
    logic       mem_we;     // Working memory write strobe
    logic [7:0] mem_wa;     // Working memory write address
    logic [5:0] mem_wd;     // Working memory write data
    logic [5:0] work_rd;    // Working word at the address register
    logic [7:0] rd_word;    // Read mux output
    logic       last_tick;  // Final tick of a word

    // True on a register write to the given offset
    function automatic logic dcs_hit(input logic       wr,
                                     input logic [7:0] addr,
                                     input logic [7:0] off);
        dcs_hit = wr && (addr == off);
    endfunction

    // Ticks only while a timed cycle runs
    assign seq_run = (s_reg.seq == SEQ_START_A) || (s_reg.seq == SEQ_XFER);

    // Both timed cycles run from the same divided clock
    dcs_cal_divider u_div (
        .clock   (clock),
        .rst_n   (rst_n),
        .run     (seq_run),
        .div_sel (s_reg.cal_div),
        .tick    (cal_tick)
    ); // R14

    // Port a serves register reads, port b the analog core
    dcs_trim_mem u_mem (
        .clock   (clock),
        .rst_n   (rst_n),
        .we      (mem_we),
        .waddr   (mem_wa),
        .wdata   (mem_wd),
        .raddr_a (s_reg.trim_addr),
        .rdata_a (work_rd),
        .raddr_b (core_trim_addr),
        .rdata_b (core_trim_data)
    );

    // Factory memory follows the sequencer during a transfer
    assign factory_addr = (s_reg.seq == SEQ_XFER) ? s_reg.seq_addr
                                                  : s_reg.trim_addr;

    // Word boundary inside a timed cycle
    assign last_tick = (s_reg.seq == SEQ_START_A) ?
                       (s_reg.seq_tick == SC_TICK_LAST) :
                       (s_reg.seq_tick == XF_TICK_LAST);

    // Register read mux
    always_comb begin
        rd_word = '0;
        case (reg_addr)
            ADDR_SYNC_CTRL: begin
                rd_word[BIT_MANUAL] = s_reg.manual_sync;
                rd_word[BIT_ALARM]  = s_reg.sync_alarm; // R1
            end
            ADDR_CAL_STAT: begin
                rd_word[TRIM_ST_LSB +: 2] = s_reg.trim_state; // R2
                rd_word[CAL_DIV_LSB +: 3] = s_reg.cal_div;
            end
            ADDR_CAL_CTRL: begin
                rd_word[BIT_SC_DONE]   = s_reg.sc_done; // R7
                rd_word[BIT_SC_START]  = (s_reg.seq == SEQ_START_A);
                rd_word[BIT_XF_DONE]   = s_reg.xf_done; // R11
                rd_word[BIT_XF_START]  = (s_reg.seq == SEQ_XFER);
                rd_word[EN_LSB +: 3]   = s_reg.mem_en;
                rd_word[BIT_FORCE_DEFAULT_TRIM]     = s_reg.force_def; // R19
            end
            ADDR_TRIM_ADDR: begin
                rd_word = s_reg.trim_addr; // R16
            end
            ADDR_TRIM_DATA: begin
                rd_word[5:0] = s_reg.trim_data; // R17
            end
            ADDR_QUAD_STAT: begin
                rd_word[1:0] = s_reg.cur_quad; // R20
            end
            ADDR_QUAD_OVR: begin
                rd_word[BIT_EXT_QUAD]       = s_reg.ext_quad_en;
                rd_word[QUAD_SEL_LSB +: 2]  = s_reg.ext_quad;
            end
            default: begin
                rd_word = '0; // Unmapped and soft reset read as zero
            end
        endcase
    end

    // Sequencer, register writes and status in one pass
    always_comb begin
        s_next          = s_reg;
        mem_we          = 1'b0;
        mem_wa          = s_reg.seq_addr;
        mem_wd          = TRIM_DEFAULT;
        s_next.sync_upd = 1'b0;

        // Alarm status follows the synchronizer; quadrant status follows the override when enabled, else the synchronizer
        s_next.sync_alarm = sync_alarm_in; // R1
        s_next.cur_quad   = s_reg.ext_quad_en ? s_reg.ext_quad
                                              : sync_auto_quadrant; // R20 R21

        // Sequencer
        case (s_reg.seq)
            SEQ_FILL: begin
                // One default word per clock; writes are blocked meanwhile
                mem_we          = 1'b1; // R18
                s_next.seq_addr = s_reg.seq_addr + 8'h01;
                if (s_reg.seq_addr == WORD_LAST) begin
                    s_next.seq        = SEQ_IDLE;
                    s_next.fill_done  = 1'b1;
                    s_next.trim_state = TRIM_FORCE_DEFAULT_TRIM; // R2
                end
            end
            SEQ_IDLE: begin
                // A freshly set uncalibrated bit reloads every word
                if (s_reg.force_def && !s_reg.fill_done) begin
                    s_next.seq      = SEQ_FILL; // R18
                    s_next.seq_addr = '0;
                end
            end
            SEQ_START_A, SEQ_XFER: begin
                // A word is committed after its share of calibration ticks
                if (cal_tick) begin // R14
                    if (last_tick) begin
                        s_next.seq_tick = '0;
                        mem_we          = 1'b1;
                        mem_wd          = (s_reg.seq == SEQ_START_A) ?
                                          start_a_result : factory_data; // R8 R12
                        s_next.seq_addr = s_reg.seq_addr + 8'h01;
                        if (s_reg.seq_addr == WORD_LAST) begin
                            s_next.seq = SEQ_IDLE;
                            if (s_reg.seq == SEQ_START_A) begin
                                s_next.sc_done    = 1'b1; // R7 R10
                                s_next.trim_state = TRIM_SELF;
                            end else begin
                                s_next.xf_done    = 1'b1; // R11 R13
                                s_next.trim_state = TRIM_FACT;
                            end
                        end
                    end else begin
                        s_next.seq_tick = s_reg.seq_tick + 4'h1;
                    end
                end
            end
            default: begin
                s_next.seq = SEQ_IDLE;
            end
        endcase

        // Calibration clock setting
        if (dcs_hit(reg_wr, reg_addr, ADDR_CAL_STAT)) begin
            s_next.cal_div = reg_wdata[CAL_DIV_LSB +: 3]; // R3 R4 R5 R6
        end

        // Calibration control; starts need idle and bits 3:0 clear
        if (dcs_hit(reg_wr, reg_addr, ADDR_CAL_CTRL)) begin
            s_next.mem_en    = reg_wdata[EN_LSB +: 3]; // R15
            s_next.force_def = reg_wdata[BIT_FORCE_DEFAULT_TRIM];   // R18 R19
            if (!reg_wdata[BIT_FORCE_DEFAULT_TRIM] || !s_reg.force_def) begin
                s_next.fill_done = 1'b0;
            end
            if ((s_reg.seq == SEQ_IDLE) &&
                (reg_wdata[3:0] == ACC_BITS_ZERO)) begin // R9 R12
                if (reg_wdata[BIT_SC_START]) begin
                    s_next.seq      = SEQ_START_A; // R8
                    s_next.seq_addr = '0;
                    s_next.seq_tick = '0;
                    s_next.sc_done  = 1'b0;
                end else if (reg_wdata[BIT_XF_START]) begin
                    s_next.seq      = SEQ_XFER; // R12
                    s_next.seq_addr = '0;
                    s_next.seq_tick = '0;
                    s_next.xf_done  = 1'b0;
                end
            end
        end

        // Address register
        if (dcs_hit(reg_wr, reg_addr, ADDR_TRIM_ADDR)) begin
            s_next.trim_addr = reg_wdata; // R16
        end

        // Read modes keep the data register tracking the addressed word
        if (s_reg.mem_en == EN_WORK_RD) begin
            s_next.trim_data = work_rd; // R15 R24
        end else if (s_reg.mem_en == EN_FACT_RD) begin
            s_next.trim_data = factory_data; // R15 R24
        end

        // Data register; a write commits only with the write enable alone
        if (dcs_hit(reg_wr, reg_addr, ADDR_TRIM_DATA)) begin
            s_next.trim_data = reg_wdata[5:0]; // R17
            if ((s_reg.mem_en == EN_WORK_WR) && (s_reg.seq == SEQ_IDLE) &&
                !s_reg.force_def) begin // R24 R19
                mem_we            = 1'b1; // R15
                mem_wa            = s_reg.trim_addr;
                mem_wd            = reg_wdata[5:0];
                s_next.trim_state = TRIM_USER; // R2
            end
        end

        // Synchronizer mode and manual update request
        if (dcs_hit(reg_wr, reg_addr, ADDR_SYNC_CTRL)) begin
            s_next.manual_sync = reg_wdata[BIT_MANUAL]; // R23
            s_next.sync_upd    = reg_wdata[BIT_SYNC_UPD] &&
                                 reg_wdata[BIT_MANUAL]; // R23
        end

        // Quadrant override
        if (dcs_hit(reg_wr, reg_addr, ADDR_QUAD_OVR)) begin
            s_next.ext_quad_en = reg_wdata[BIT_EXT_QUAD];       // R21
            s_next.ext_quad    = reg_wdata[QUAD_SEL_LSB +: 2];  // R21
        end

        // Read data is held between reads
        if (reg_rd) begin
            s_next.rdata = rd_word;
        end

        // Soft reset clears registers but never touches memory contents
        if (dcs_hit(reg_wr, reg_addr, ADDR_SOFT_RST) &&
            reg_wdata[BIT_SOFT_RST]) begin
            s_next            = '0; // R22
            s_next.seq        = SEQ_IDLE;
            s_next.trim_state = TRIM_FORCE_DEFAULT_TRIM; // R22
        end
    end

    // State register; hard reset also reloads defaults into memory
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg     <= '0;
            s_reg.seq <= SEQ_FILL;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    assign reg_rdata           = s_reg.rdata;
    assign sync_quadrant_sel   = s_reg.cur_quad; // R21
    assign sync_auto_update_en = !s_reg.manual_sync; // R23
    assign sync_update_pulse   = s_reg.sync_upd;
endmodule

// [hw/dcs_pkg.sv]
// Behaviour
// R1 - Alarm bit 0 mirrors synchronizer update need
// R2 - Bits 5:4 report working trim memory state
// R3 - Divider setting 000 gives sample clock /4096
// R4 - Settings 001,010,011 give /2048,/1024,/512
// R5 - Each setting step doubles calibration clock rate; code doubles only through 011, settings 100 and up all give /32
// R6 - Fastest settings give sample clock /32
// R7 - Bit 7 flags self-calibration finished
// R8 - Bit 6 starts self-calibration into working memory
// R9 - Software keeps bits 3:0 zero when starting
// R10 - Self-calibration lasts about 100 ms at /4096
// R11 - Bit 5 flags memory transfer finished
// R12 - Bit 4 starts factory-to-working copy
// R13 - Transfer lasts about 15 ms at /4096; code uses one tick per word, 256 ticks, about 10.5 ms at 100 MHz
// R14 - Transfer steps on the divided calibration clock
// R15 - Bits 3,2,1 enable working write/read, factory read
// R16 - Address register 0x10 selects trim word
// R17 - Data register 0x11 carries trim word data
// R18 - Uncalibrated bit forces all words to default
// R19 - Uncalibrated bit stays set until software clears
// R20 - Register 0x15 reports quadrant in use
// R21 - Bit 5 of 0x16 selects software quadrant
// R22 - Soft reset self-clears, keeps memory, reports uncalibrated
// R23 - Manual sync bit stops automatic synchronizer updates
// R24 - One access enable at a time, address first
package dcs_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SOFT_RST  = 8'h00;
    localparam logic [7:0] ADDR_SYNC_CTRL = 8'h02;
    localparam logic [7:0] ADDR_CAL_STAT  = 8'h0E;
    localparam logic [7:0] ADDR_CAL_CTRL  = 8'h0F;
    localparam logic [7:0] ADDR_TRIM_ADDR = 8'h10;
    localparam logic [7:0] ADDR_TRIM_DATA = 8'h11;
    localparam logic [7:0] ADDR_QUAD_STAT = 8'h15;
    localparam logic [7:0] ADDR_QUAD_OVR  = 8'h16;
    // Field positions
    localparam int BIT_SOFT_RST   = 7;
    localparam int BIT_MANUAL     = 2;
    localparam int BIT_SYNC_UPD   = 1;
    localparam int BIT_ALARM      = 0;
    localparam int TRIM_ST_LSB    = 4;
    localparam int CAL_DIV_LSB    = 0;
    localparam int BIT_SC_DONE    = 7;
    localparam int BIT_SC_START   = 6;
    localparam int BIT_XF_DONE    = 5;
    localparam int BIT_XF_START   = 4;
    localparam int EN_LSB         = 1;
    localparam int BIT_FORCE_DEFAULT_TRIM      = 0;
    localparam int BIT_EXT_QUAD   = 5;
    localparam int QUAD_SEL_LSB   = 3;
    // Access enable codes on bits 3:1
    localparam logic [2:0] EN_WORK_WR = 3'h4;
    localparam logic [2:0] EN_WORK_RD = 3'h2;
    localparam logic [2:0] EN_FACT_RD = 3'h1;
    localparam logic [3:0] ACC_BITS_ZERO = 4'h0;
    // Working memory state codes
    localparam logic [1:0] TRIM_FORCE_DEFAULT_TRIM = 2'h0;
    localparam logic [1:0] TRIM_SELF  = 2'h1;
    localparam logic [1:0] TRIM_FACT  = 2'h2;
    localparam logic [1:0] TRIM_USER  = 2'h3;
    localparam logic [5:0] TRIM_DEFAULT = 6'h3F;
    localparam logic [7:0] WORD_LAST    = 8'hFF;
    localparam int         TRIM_WORDS   = 256;
    // Divider terminal counts (ratio minus one)
    localparam logic [11:0] DIV_LAST_4096 = 12'hFFF;
    localparam logic [11:0] DIV_LAST_2048 = 12'h7FF;
    localparam logic [11:0] DIV_LAST_1024 = 12'h3FF;
    localparam logic [11:0] DIV_LAST_512  = 12'h1FF;
    localparam logic [11:0] DIV_LAST_32   = 12'h01F;
    // Cycle durations, stated at the reference rate and slowest ratio
    localparam int START_A_TIME_US = 100000;
    localparam int XFER_TIME_US    = 15000;
    localparam int REF_RATE_MHZ    = 100;
    localparam int REF_RATIO       = 4096;
    localparam int SC_TICKS_WORD =
        START_A_TIME_US * REF_RATE_MHZ / REF_RATIO / TRIM_WORDS;
    localparam int XF_TICKS_WORD =
        XFER_TIME_US * REF_RATE_MHZ / REF_RATIO / TRIM_WORDS;
    localparam logic [3:0] SC_TICK_LAST = 4'(SC_TICKS_WORD - 1);
    localparam logic [3:0] XF_TICK_LAST = 4'(XF_TICKS_WORD - 1);
    // Sequencer states, Gray order along fill, idle, start_a, transfer
    typedef enum logic [1:0] {
        SEQ_FILL    = 2'h2,
        SEQ_IDLE    = 2'h0,
        SEQ_START_A = 2'h1,
        SEQ_XFER    = 2'h3
    } dcs_seq_t;
endpackage

// [hw/dcs_cal_divider.sv]
`timescale 1ns/1ps
// Calibration clock as a one-cycle tick stream on the sample clock
module dcs_cal_divider
    import dcs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] div_sel,
    output logic            tick
);
    // Counter and tick flop
    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } dcs_div_t;

    dcs_div_t s_reg;  // Registered state
    dcs_div_t s_next; // Next state

    // Setting to terminal count; steps 0 to 3 halve the ratio, settings 4 and up give 32
    function automatic logic [11:0] dcs_div_last(input logic [2:0] sel);
        case (sel)
            3'h0:    dcs_div_last = DIV_LAST_4096; // R3
            3'h1:    dcs_div_last = DIV_LAST_2048; // R4 R5
            3'h2:    dcs_div_last = DIV_LAST_1024; // R4 R5
            3'h3:    dcs_div_last = DIV_LAST_512;  // R4 R5
            default: dcs_div_last = DIV_LAST_32;   // R6
        endcase
    endfunction

    // Count while a cycle runs; restart so every cycle sees full periods
    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (!run) begin
            s_next.cnt = '0;
        end else if (s_reg.cnt >= dcs_div_last(div_sel)) begin
            s_next.cnt  = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 12'h001;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule

// [hw/dcs_trim_mem.sv]
`timescale 1ns/1ps
// Working trim memory: one write port, two registered read ports
module dcs_trim_mem
    import dcs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [5:0] wdata,
    input  wire logic [7:0] raddr_a,
    output logic      [5:0] rdata_a,
    input  wire logic [7:0] raddr_b,
    output logic      [5:0] rdata_b
);
    // Read data flops
    typedef struct packed {
        logic [5:0] rd_a;
        logic [5:0] rd_b;
    } dcs_mem_t;

    logic [5:0] mem [0:TRIM_WORDS-1]; // Trim words, filled after reset
    dcs_mem_t   s_reg;                // Registered state
    dcs_mem_t   s_next;               // Next state

    // Reads see the old word on a same-address write
    always_comb begin
        s_next      = s_reg;
        s_next.rd_a = mem[raddr_a];
        s_next.rd_b = mem[raddr_b];
    end

    // Array has no reset; the sequencer loads defaults instead
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read flops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_a = s_reg.rd_a;
    assign rdata_b = s_reg.rd_b;
endmodule

// [dv/dcs_regs_asserts.sv]
`timescale 1ns/1ps
// Port-level checks of the calibration and sync register block
module dcs_regs_asserts
    import dcs_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       sync_alarm_in,
    input wire logic [1:0] sync_auto_quadrant,
    input wire logic [1:0] sync_quadrant_sel,
    input wire logic       sync_auto_update_en,
    input wire logic       sync_update_pulse
);
    logic ext_reg; // Mirror of the external quadrant enable
    logic man_reg; // Mirror of the manual sync bit
    logic soft_wr; // Soft reset write seen this cycle
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    assign soft_wr = reg_wr && reg_addr == ADDR_SOFT_RST && reg_wdata[BIT_SOFT_RST];
    // Mirrors follow writes; soft reset clears them like the real bits
    always_ff @(posedge clock) begin
        if (!rst_n || soft_wr) begin
            ext_reg <= 1'b0;
            man_reg <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_QUAD_OVR) begin
            ext_reg <= reg_wdata[BIT_EXT_QUAD];
        end else if (reg_wr && reg_addr == ADDR_SYNC_CTRL) begin
            man_reg <= reg_wdata[BIT_MANUAL];
        end
    end
    a_rdata_hold: assert property (!reg_rd && !soft_wr |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
        else $error("unmapped offset read nonzero");
    a_alarm_read: assert property (reg_rd && reg_addr == ADDR_SYNC_CTRL
        |=> reg_rdata[BIT_ALARM] == $past(sync_alarm_in, 2))
        else $error("alarm bit does not follow input");
    a_quad_status: assert property (reg_rd && reg_addr == ADDR_QUAD_STAT
        |=> reg_rdata == {6'h00, $past(sync_quadrant_sel)})
        else $error("quadrant status differs from quadrant in use");
    a_ext_quad: assert property (reg_wr && reg_addr == ADDR_QUAD_OVR
        && reg_wdata[BIT_EXT_QUAD] ##1 !soft_wr |=> sync_quadrant_sel == $past(reg_wdata[4:3], 2))
        else $error("external quadrant not applied");
    a_auto_quad: assert property (!ext_reg && !soft_wr ##1 !ext_reg
        |-> sync_quadrant_sel == $past(sync_auto_quadrant))
        else $error("automatic quadrant not followed");
    a_manual_en: assert property (man_reg == $past(man_reg)
        |-> sync_auto_update_en == !man_reg)
        else $error("auto update enable wrong for manual bit");
    a_update_pulse: assert property (reg_wr && reg_addr == ADDR_SYNC_CTRL
        && reg_wdata[2:1] == 2'h3 |=> sync_update_pulse ##1 !sync_update_pulse)
        else $error("manual update pulse missing or long");
endmodule
bind dcs_regs dcs_regs_asserts u_asserts (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sync_alarm_in(sync_alarm_in), .sync_auto_quadrant(sync_auto_quadrant),
    .sync_quadrant_sel(sync_quadrant_sel), .sync_auto_update_en(sync_auto_update_en),
    .sync_update_pulse(sync_update_pulse));

// [dv/tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench for the calibration register block
module tb_top;
    import dcs_pkg::*;
    logic        clock, rst_n, reg_wr, reg_rd, rd_d, sync_alarm_in;
    logic        sync_auto_update_en, sync_update_pulse;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, factory_addr, core_trim_addr, v, a;
    logic [1:0]  sync_auto_quadrant, sync_quadrant_sel;
    logic [5:0]  start_a_result, core_trim_data, d;
    logic [15:0] ent;
    logic [15:0] exp_q[$]; // Mask and value of each pending read
    int          mismatches, checks, n;
    wire logic [5:0] factory_data;
    // Factory word is a fixed scramble of its address
    assign factory_data = factory_addr[5:0] ^ 6'h2A;
    dcs_regs u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sync_alarm_in(sync_alarm_in), .sync_auto_quadrant(sync_auto_quadrant),
        .sync_quadrant_sel(sync_quadrant_sel), .sync_auto_update_en(sync_auto_update_en),
        .sync_update_pulse(sync_update_pulse), .start_a_result(start_a_result),
        .factory_addr(factory_addr), .factory_data(factory_data),
        .core_trim_addr(core_trim_addr), .core_trim_data(core_trim_data));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One write strobe; the gap cycle keeps strobes apart
    task automatic wr(logic [7:0] ad, logic [7:0] wd);
        @(negedge clock);
        reg_addr = ad;
        reg_wdata = wd;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    // Read strobe; the expectation goes to the monitor's queue
    task automatic rd(logic [7:0] ad, logic [7:0] e, logic [7:0] m);
        @(negedge clock);
        reg_addr = ad;
        reg_rd = 1'b1;
        exp_q.push_back({m, e});
        @(negedge clock);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
    // Trim word through the data register in a read mode
    task automatic rd_word(logic [7:0] ad, logic [7:0] e, logic [7:0] ctl);
        wr(ADDR_TRIM_ADDR, ad);
        wr(ADDR_CAL_CTRL, ctl);
        repeat (2) @(negedge clock);
        rd(ADDR_TRIM_DATA, e, 8'h3F);
    endtask
    // Poll a done flag and check the run time against its nominal count
    task automatic wait_flag(int b, int nom);
        n = 0;
        v = 8'h00;
        while (v[b] !== 1'b1 && n < nom + 256) begin
            rd(ADDR_CAL_CTRL, 8'h00, 8'h00);
            n += 2;
        end
        cmp("cycle_window", 8'h01, {7'h00, (n >= nom - 64 && n < nom + 256)});
    endtask
    // Monitor: reply seen at the edge after the strobe; mask zero is a poll
    always @(posedge clock) begin
        if (rd_d) begin
            ent = exp_q.pop_front();
            if (ent[15:8] != 8'h00) cmp("reg_rdata", ent[7:0], reg_rdata & ent[15:8]);
        end
        rd_d <= reg_rd;
    end
    // Watchdog somewhat above the longest expected run
    initial begin
        #4000000;
        mismatches++;
        complete_run();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, sync_alarm_in, reg_addr, reg_wdata, core_trim_addr} = '0;
        sync_auto_quadrant = 2'h2;
        start_a_result = 6'h00;
        void'($urandom(11));
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (300) @(negedge clock);
        rd(ADDR_TRIM_ADDR, 8'h00, 8'hFF);
        rd(ADDR_TRIM_DATA, 8'h00, 8'hFF);
        rd(ADDR_CAL_STAT, 8'h00, 8'hFF);
        rd(ADDR_QUAD_STAT, 8'h02, 8'hFF);
        rd(8'h30, 8'h00, 8'hFF);
        a = 8'($urandom);
        d = 6'($urandom);
        wr(ADDR_TRIM_ADDR, a);
        wr(ADDR_CAL_CTRL, 8'h08);
        wr(ADDR_TRIM_DATA, {2'h0, d});
        rd(ADDR_CAL_STAT, 8'h30, 8'h30);
        rd_word(a, {2'h0, d}, 8'h04);
        core_trim_addr = a;
        repeat (2) @(negedge clock);
        cmp("core_trim_data", {2'h0, d}, {2'h0, core_trim_data});
        rd_word(a, {2'h0, a[5:0] ^ 6'h2A}, 8'h02);
        wr(ADDR_CAL_CTRL, 8'h12);
        rd(ADDR_CAL_CTRL, 8'h02, 8'hFF);
        wr(ADDR_CAL_STAT, 8'h04);
        wr(ADDR_CAL_CTRL, 8'h10);
        wait_flag(BIT_XF_DONE, 256 * 32);
        rd(ADDR_CAL_STAT, 8'h24, 8'hFF);
        a = 8'($urandom);
        rd_word(a, {2'h0, a[5:0] ^ 6'h2A}, 8'h04);
        wr(ADDR_CAL_STAT, 8'h03);
        wr(ADDR_CAL_CTRL, 8'h10);
        repeat (513) @(negedge clock);
        cmp("factory_addr", 8'h01, factory_addr);
        wr(ADDR_SOFT_RST, 8'h80);
        d = 6'($urandom);
        start_a_result = d;
        wr(ADDR_CAL_STAT, 8'h06);
        wr(ADDR_CAL_CTRL, 8'h40);
        wait_flag(BIT_SC_DONE, 256 * 9 * 32);
        rd(ADDR_CAL_STAT, 8'h16, 8'hFF);
        rd_word(a, {2'h0, d}, 8'h04);
        wr(ADDR_SOFT_RST, 8'h80);
        rd(ADDR_SOFT_RST, 8'h00, 8'h80);
        rd(ADDR_CAL_STAT, 8'h00, 8'hFF);
        rd_word(a, {2'h0, d}, 8'h04);
        wr(ADDR_CAL_CTRL, 8'h01);
        repeat (300) @(negedge clock);
        rd_word(a, 8'h3F, 8'h05);
        rd(ADDR_CAL_CTRL, 8'h05, 8'h0F);
        sync_alarm_in = 1'b1;
        repeat (2) @(negedge clock);
        rd(ADDR_SYNC_CTRL, 8'h01, 8'h01);
        sync_alarm_in = 1'b0;
        for (int q = 0; q < 4; q++) begin
            wr(ADDR_QUAD_OVR, 8'(8'h20 | (q << 3)));
            rd(ADDR_QUAD_STAT, 8'(q), 8'hFF);
            cmp("quadrant_sel", 8'(q), {6'h00, sync_quadrant_sel});
        end
        wr(ADDR_QUAD_OVR, 8'h00);
        sync_auto_quadrant = 2'($urandom);
        repeat (2) @(negedge clock);
        cmp("quadrant_sel", {6'h00, sync_auto_quadrant}, {6'h00, sync_quadrant_sel});
        wr(ADDR_SYNC_CTRL, 8'h04);
        @(negedge clock);
        cmp("auto_update_en", 8'h00, {7'h00, sync_auto_update_en});
        wr(ADDR_SYNC_CTRL, 8'h06);
        cmp("update_pulse", 8'h01, {7'h00, sync_update_pulse});
        repeat (4) @(negedge clock);
        complete_run();
    end
endmodule
